/* File: rss_pkg.sv */
// constants for the reset, semi-suspend and suspend sequencer
// Contract
// - any reset restores defaults, clears addresses, interrupts
// - power-on cause bit 4, watchdog bit 6
// - restart at address zero, nothing pushed
// - CPU held, other blocks run during semi-suspend
// - 1 ms locked, then 95 ms hold
// - upstream bus reset aborts hold, starts immediately
// - early bus reset stays pending until enabled
// - supply dip repeats the whole sequence
// - any write to watchdog clear restarts it
// - rollover loads status 010X0001, resets
// - watchdog reset held 2 ms
// - transmitter off until addresses reprogrammed
// - power-on flag has precedence over watchdog flag
// - suspend stops oscillator, PLL and timers
// - wake on GPIO interrupt or bus activity
// - CPU ready 1 ms after oscillator stable
// - next instruction runs before any interrupt
`default_nettype none
package rss_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int POR_LOCK_US = 1_000;
  localparam int SEMI_HOLD_US = 95_000;
  localparam int WDR_HOLD_US = 2_000;
  localparam int WAKE_DELAY_US = 1_000;
  localparam int WATCHDOG_TIMEOUT_US = 8_192;
  localparam int POR_LOCK_CYC = POR_LOCK_US * CYC_PER_US;
  localparam int SEMI_HOLD_CYC = SEMI_HOLD_US * CYC_PER_US;
  localparam int WDR_HOLD_CYC = WDR_HOLD_US * CYC_PER_US;
  localparam int WAKE_DELAY_CYC = WAKE_DELAY_US * CYC_PER_US;
  localparam int WATCHDOG_TIMEOUT_CYC = WATCHDOG_TIMEOUT_US * CYC_PER_US;
  localparam int HOLD_CNT_W = 21;
  localparam int WD_CNT_W = 24;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_WATCHDOG_CLEAR = 8'h26;
  localparam logic [7:0] ADDR_STATUS_CONTROL = 8'hFF;

  // ------------------------------------------------------------
  // status and control fields
  // ------------------------------------------------------------
  localparam int RUN_BIT = 0;
  localparam int IRQ_SENSE_BIT = 2;
  localparam int SUSPEND_BIT = 3;
  localparam int POR_FLAG_BIT = 4;
  localparam int WDR_FLAG_BIT = 6;
  localparam logic [7:0] STATUS_WRITE_MASK = 8'h0D;
  localparam logic [7:0] STATUS_POR_VALUE = 8'h11;
  localparam logic [7:0] STATUS_WDR_VALUE = 8'h41;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POR_LOCK,
    ST_SEMI_HOLD,
    ST_RUN,
    ST_WDR_HOLD,
    ST_SUSPEND,
    ST_WAKE
  } seq_state_t;

endpackage
`default_nettype wire

/* File: watchdog_if.sv */
// watchdog control and rollover signals between sequencer and timer
`default_nettype none
interface watchdog_if;
  logic clear;
  logic run;
  logic rollover;
  modport timer (input clear, input run, output rollover);
  modport ctrl (output clear, output run, input rollover);
endinterface
`default_nettype wire

/* File: watchdog_timer.sv */
// watchdog counter with restart and rollover pulse
`default_nettype none
module watchdog_timer
  import rss_pkg::*;
#(
  parameter int TIMEOUT_CYC = WATCHDOG_TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  watchdog_if.timer wd
);

  generate
    if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << WD_CNT_W)) begin : g_bad
      $error("watchdog timeout out of range");
    end
  endgenerate

  localparam logic [WD_CNT_W-1:0] LAST = WD_CNT_W'(TIMEOUT_CYC - 1);

  logic [WD_CNT_W-1:0] cnt_q;
  logic [WD_CNT_W-1:0] cnt_d;
  logic roll_q;
  wire at_last = (cnt_q == LAST);

  // any clear write or a low run input restarts the count
  assign cnt_d = (wd.clear || !wd.run || at_last) ? '0 : cnt_q + WD_CNT_W'(1);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      roll_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      roll_q <= wd.run && !wd.clear && at_last;
    end
  end

  assign wd.rollover = roll_q;

endmodule
`default_nettype wire

/* File: reset_suspend_sequencer.sv */
// reset, semi-suspend, watchdog and suspend sequencer
`default_nettype none
module reset_suspend_sequencer
  import rss_pkg::*;
#(
  parameter int POR_LOCK_CYCLES = POR_LOCK_CYC,
  parameter int SEMI_HOLD_CYCLES = SEMI_HOLD_CYC,
  parameter int WDR_HOLD_CYCLES = WDR_HOLD_CYC,
  parameter int WAKE_DELAY_CYCLES = WAKE_DELAY_CYC,
  parameter int WATCHDOG_CYCLES = WATCHDOG_TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic usb_bus_reset,
  input wire logic bus_reset_ie,
  input wire logic global_ie,
  input wire logic bus_reset_ack,
  input wire logic dev_addr_written,
  input wire logic gpio_irq_wake,
  input wire logic usb_activity,
  input wire logic osc_stable,
  input wire logic instr_done,
  output logic cpu_hold,
  output logic fetch_restart,
  output logic block_reset,
  output logic usb_tx_enable,
  output logic clocks_enable,
  output logic bus_reset_pending,
  output logic bus_reset_irq,
  output logic irq_defer
);

  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  generate
    if (POR_LOCK_CYCLES < 1 || SEMI_HOLD_CYCLES < 1 || WDR_HOLD_CYCLES < 1 || WAKE_DELAY_CYCLES < 1 ||
        POR_LOCK_CYCLES >= (1 << HOLD_CNT_W) || SEMI_HOLD_CYCLES >= (1 << HOLD_CNT_W) ||
        WDR_HOLD_CYCLES >= (1 << HOLD_CNT_W) || WAKE_DELAY_CYCLES >= (1 << HOLD_CNT_W)) begin : g_bad
      $error("hold counts out of range");
    end
  endgenerate

  function automatic logic [HOLD_CNT_W-1:0] last_of(input int cycles);
    last_of = HOLD_CNT_W'(cycles - 1);
  endfunction

  // terminal counts of the hold, reset and wake stretches
  localparam logic [HOLD_CNT_W-1:0] LOCK_LAST = last_of(POR_LOCK_CYCLES);
  localparam logic [HOLD_CNT_W-1:0] SEMI_LAST = last_of(SEMI_HOLD_CYCLES);
  localparam logic [HOLD_CNT_W-1:0] WDR_LAST = last_of(WDR_HOLD_CYCLES);
  localparam logic [HOLD_CNT_W-1:0] WAKE_LAST = last_of(WAKE_DELAY_CYCLES);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  // supply dips pull nrst low; release restarts the sequence
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire wr_status = io_wr && (io_addr == ADDR_STATUS_CONTROL);
  wire wr_wd_clear = io_wr && (io_addr == ADDR_WATCHDOG_CLEAR);
  wire rd_status = io_rd && (io_addr == ADDR_STATUS_CONTROL);

  // ------------------------------------------------------------
  // state and counters
  // ------------------------------------------------------------
  seq_state_t state_q;
  seq_state_t state_d;
  logic [HOLD_CNT_W-1:0] cnt_q;
  logic [HOLD_CNT_W-1:0] cnt_d;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic pending_q;
  logic tx_en_q;
  logic defer_q;
  logic restart_q;
  logic block_rst_q;
  logic clk_en_q;
  logic [7:0] rdata_q;

  // ------------------------------------------------------------
  // state decode
  // ------------------------------------------------------------
  wire in_semi = (state_q == ST_SEMI_HOLD);
  wire in_run = (state_q == ST_RUN);
  wire in_wdr = (state_q == ST_WDR_HOLD);
  wire in_wake = (state_q == ST_WAKE);

  watchdog_if wd ();

  watchdog_timer #(
    .TIMEOUT_CYC(WATCHDOG_CYCLES)
  ) u_watchdog (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wd(wd)
  );

  // timer runs only while the CPU runs
  assign wd.run = in_run;
  assign wd.clear = wr_wd_clear;

  wire watchdog_fire = wd.rollover && in_run;
  wire suspend_req = wr_status && io_wdata[SUSPEND_BIT] && in_run;
  wire wake_event = gpio_irq_wake || usb_activity;
  wire run_armed = status_q[RUN_BIT];

  wire lock_done = (cnt_q == LOCK_LAST);
  wire semi_done = (cnt_q == SEMI_LAST);
  wire wdr_done = (cnt_q == WDR_LAST);
  wire wake_done = (cnt_q == WAKE_LAST);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + HOLD_CNT_W'(1);
    case (state_q)
      ST_POR_LOCK: begin
        // first stretch ignores bus reset
        if (lock_done) begin
          state_d = ST_SEMI_HOLD;
          cnt_d = '0;
        end
      end
      ST_SEMI_HOLD: begin
        if (usb_bus_reset || semi_done) begin
          state_d = ST_RUN;
          cnt_d = '0;
        end
      end
      ST_RUN: begin
        cnt_d = '0;
        if (watchdog_fire) begin
          state_d = ST_WDR_HOLD;
        end else if (suspend_req) begin
          state_d = ST_SUSPEND;
        end
      end
      ST_WDR_HOLD: begin
        if (wdr_done) begin
          state_d = ST_RUN;
          cnt_d = '0;
        end
      end
      ST_SUSPEND: begin
        cnt_d = '0;
        if (wake_event && run_armed) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // delay counts only once the oscillator is stable
        if (!osc_stable) begin
          cnt_d = '0;
        end else if (wake_done) begin
          state_d = ST_RUN;
          cnt_d = '0;
        end
      end
      default: begin
        state_d = ST_POR_LOCK;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_POR_LOCK;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // ------------------------------------------------------------
  // status and control register
  // ------------------------------------------------------------
  wire enter_wdr = in_run && (state_d == ST_WDR_HOLD);
  wire leave_suspend = in_wake && (state_d == ST_RUN);
  wire [7:0] wr_flags = status_q & io_wdata & ((8'h01 << POR_FLAG_BIT) | (8'h01 << WDR_FLAG_BIT));

  always_comb begin
    status_d = status_q;
    if (enter_wdr) begin
      // power-on flag is kept so it can override the watchdog flag
      status_d = STATUS_WDR_VALUE;
      status_d[POR_FLAG_BIT] = status_q[POR_FLAG_BIT];
    end else if (wr_status) begin
      // cause flags can only be cleared by firmware
      status_d = (io_wdata & STATUS_WRITE_MASK) | wr_flags;
    end else if (leave_suspend) begin
      status_d[SUSPEND_BIT] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= STATUS_POR_VALUE;
    end else begin
      status_q <= status_d;
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= READ_ZERO;
    end else if (rd_status) begin
      rdata_q <= status_q;
    end else if (io_rd) begin
      rdata_q <= READ_ZERO;
    end
  end

  assign io_rdata = rdata_q;

  // ------------------------------------------------------------
  // bus reset pending flag
  // ------------------------------------------------------------
  wire bus_reset_seen = usb_bus_reset && (in_semi || in_run);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_q <= 1'b0;
    end else if (state_q == ST_WDR_HOLD) begin
      pending_q <= 1'b0;
    end else if (bus_reset_seen) begin
      // set wins over acknowledge in the same cycle
      pending_q <= 1'b1;
    end else if (bus_reset_ack) begin
      pending_q <= 1'b0;
    end
  end

  assign bus_reset_pending = pending_q;
  // serviced only once both enables are set and no wake defer
  assign bus_reset_irq = pending_q && bus_reset_ie && global_ie && !defer_q && (state_q == ST_RUN);

  // ------------------------------------------------------------
  // interrupt defer after wake
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      defer_q <= 1'b0;
    end else if (leave_suspend) begin
      defer_q <= 1'b1;
    end else if (instr_done) begin
      defer_q <= 1'b0;
    end
  end

  assign irq_defer = defer_q;

  // ------------------------------------------------------------
  // transmitter enable
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_en_q <= 1'b0;
    end else if (state_q == ST_WDR_HOLD) begin
      tx_en_q <= 1'b0;
    end else if (dev_addr_written) begin
      tx_en_q <= 1'b1;
    end
  end

  assign usb_tx_enable = tx_en_q;

  // ------------------------------------------------------------
  // block reset, fetch restart, clocks
  // ------------------------------------------------------------
  wire restart_d = (state_d == ST_RUN) && (in_semi || in_wdr);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      block_rst_q <= 1'b1;
      restart_q <= 1'b0;
      clk_en_q <= 1'b1;
    end else begin
      // restores registers, addresses, interrupt enables, stack pointers
      block_rst_q <= enter_wdr || (state_q == ST_WDR_HOLD && state_d == ST_WDR_HOLD);
      // fetch from address zero with nothing pushed
      restart_q <= restart_d;
      clk_en_q <= (state_d != ST_SUSPEND);
    end
  end

  assign fetch_restart = restart_q;
  assign block_reset = block_rst_q;
  assign clocks_enable = clk_en_q;
  // CPU waits outside run; other blocks run except in watchdog hold and suspend
  assign cpu_hold = (state_q != ST_RUN);

endmodule
`default_nettype wire

/* File: rss_assertions.sv */
// assertion checker for the reset and suspend sequencer
`default_nettype none
module rss_assertions #(
  parameter int WDR_HOLD_CYCLES = 8,
  parameter int WATCHDOG_CYCLES = 32
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic io_wr,
  input wire logic [7:0] io_addr,
  input wire logic bus_reset_ie,
  input wire logic global_ie,
  input wire logic cpu_hold,
  input wire logic fetch_restart,
  input wire logic block_reset,
  input wire logic usb_tx_enable,
  input wire logic clocks_enable,
  input wire logic bus_reset_pending,
  input wire logic bus_reset_irq,
  input wire logic irq_defer
);
  timeunit 1ns;
  timeprecision 1ns;
  int hold_q;
  int idle_q;
  logic por_q;
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hold_q <= 0;
      idle_q <= 0;
      por_q <= 1'b1;
    end else begin
      hold_q <= block_reset ? hold_q + 1 : 0;
      idle_q <= (cpu_hold || (io_wr && io_addr == 8'h26)) ? 0 : idle_q + 1;
      por_q <= block_reset ? por_q : 1'b0;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_reset_holds;
    block_reset |-> cpu_hold && !fetch_restart;
  endproperty
  a_reset_holds: assert property (p_reset_holds) else $error("cpu runs in reset");
  property p_restart;
    fetch_restart |-> !cpu_hold && !block_reset ##1 !fetch_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("bad restart pulse");
  property p_clk_hold;
    !clocks_enable |-> cpu_hold;
  endproperty
  a_clk_hold: assert property (p_clk_hold) else $error("cpu runs unclocked");
  property p_irq;
    bus_reset_irq |-> bus_reset_pending && bus_reset_ie && global_ie && !irq_defer && !cpu_hold;
  endproperty
  a_irq: assert property (p_irq) else $error("bus reset irq unqualified");
  property p_defer;
    $rose(irq_defer) |-> !cpu_hold && !fetch_restart && $past(cpu_hold);
  endproperty
  a_defer: assert property (p_defer) else $error("bad wake resume");
  property p_tx_off;
    block_reset ##1 block_reset |-> !usb_tx_enable && !bus_reset_pending;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx on in reset");
  property p_wd_bound;
    idle_q <= WATCHDOG_CYCLES + 2;
  endproperty
  a_wd_bound: assert property (p_wd_bound) else $error("watchdog missed");
  property p_wdr_len;
    $fell(block_reset) && !por_q |-> hold_q == WDR_HOLD_CYCLES;
  endproperty
  a_wdr_len: assert property (p_wdr_len) else $error("watchdog reset length");
  c_restart: cover property (fetch_restart);
  c_wake: cover property ($rose(irq_defer));
  c_wdr: cover property ($fell(block_reset) && !por_q);
endmodule
bind reset_suspend_sequencer rss_assertions #(.WDR_HOLD_CYCLES(WDR_HOLD_CYCLES), .WATCHDOG_CYCLES(WATCHDOG_CYCLES))
  u_chk (.ref_clk, .nrst, .io_wr, .io_addr, .bus_reset_ie, .global_ie, .cpu_hold, .fetch_restart,
  .block_reset, .usb_tx_enable, .clocks_enable, .bus_reset_pending, .bus_reset_irq, .irq_defer);
`default_nettype wire

/* File: cpu_osc_model.sv */
// oscillator and cpu stand-in for the sequencer's far side
`default_nettype none
module cpu_osc_model (
  input wire logic ref_clk,
  input wire logic clocks_enable,
  input wire logic cpu_hold,
  output logic osc_stable,
  output var logic instr_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] osc_q;
  logic [1:0] step_q;
  initial begin
    osc_q = 2'h3;
    step_q = 2'h0;
    instr_done = 1'b0;
  end
  // oscillator settles three cycles after restart
  assign osc_stable = clocks_enable && osc_q == 2'h3;
  always @(posedge ref_clk) begin
    osc_q <= !clocks_enable ? 2'h0 : (osc_q == 2'h3 ? osc_q : osc_q + 2'h1);
    step_q <= step_q + 2'h1;
    instr_done <= !cpu_hold && step_q == 2'h3;
  end
endmodule
`default_nettype wire

/* File: reset_suspend_sequencer_test.sv */
// self-checking bench for the reset and suspend sequencer
`default_nettype none
module reset_suspend_sequencer_test;
  import rss_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] H = 8'h80, R = 8'h40, B = 8'h20, T = 8'h10, C = 8'h08, P = 8'h04, I = 8'h02, D = 8'h01;
  logic ref_clk, nrst, io_wr, io_rd, usb_bus_reset, bus_reset_ie, global_ie, bus_reset_ack;
  logic dev_addr_written, gpio_irq_wake, usb_activity, osc_stable, instr_done, cpu_hold, fetch_restart;
  logic block_reset, usb_tx_enable, clocks_enable, bus_reset_pending, bus_reset_irq, irq_defer;
  logic [7:0] io_addr, io_wdata, io_rdata, rd_q;
  wire logic [7:0] fl = {cpu_hold, fetch_restart, block_reset, usb_tx_enable, clocks_enable, bus_reset_pending,
    bus_reset_irq, irq_defer};
  int fails, checked, n;
  reset_suspend_sequencer #(.POR_LOCK_CYCLES(4), .SEMI_HOLD_CYCLES(20), .WDR_HOLD_CYCLES(8),
    .WAKE_DELAY_CYCLES(5), .WATCHDOG_CYCLES(32)) DUT (.ref_clk, .nrst, .io_wr, .io_rd, .io_addr, .io_wdata,
    .io_rdata, .usb_bus_reset, .bus_reset_ie, .global_ie, .bus_reset_ack, .dev_addr_written, .gpio_irq_wake,
    .usb_activity, .osc_stable, .instr_done, .cpu_hold, .fetch_restart, .block_reset, .usb_tx_enable,
    .clocks_enable, .bus_reset_pending, .bus_reset_irq, .irq_defer);
  cpu_osc_model MDL (.ref_clk, .clocks_enable, .cpu_hold, .osc_stable, .instr_done);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chkf(input logic [7:0] m, input logic [7:0] v);
    chk(fl & m, v);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic pulse(ref logic s);
    @(negedge ref_clk);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge ref_clk);
    io_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge ref_clk);
    io_rd = 1'b0;
    rd_q = io_rdata;
  endtask
  task automatic wait_for(input logic [7:0] m, input logic [7:0] v);
    n = 0;
    while ((fl & m) !== v) begin
      @(negedge ref_clk);
      n++;
      if (n > 60) begin
        fails++;
        end_of_test();
      end
    end
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    {nrst, io_wr, io_rd, usb_bus_reset, bus_reset_ie, global_ie, bus_reset_ack} = 7'h00;
    {dev_addr_written, gpio_irq_wake, usb_activity} = 3'h0;
    io_addr = 8'h00;
    io_wdata = 8'h00;
    fails = 0;
    checked = 0;
    cyc(8);
    chkf(H | R | B | T | P, H | B);
    nrst = 1'b1;
    cyc(2);
    pulse(usb_bus_reset);
    chkf(H | R | P, H);
    cyc(8);
    chkf(H | C, H | C);
    pulse(usb_bus_reset);
    chkf(H | R | P | I, R | P);
    rd(8'hFF);
    chk(rd_q, 8'h11);
    bus_reset_ie = 1'b1;
    cyc(1);
    chkf(I, 8'h00);
    global_ie = 1'b1;
    cyc(1);
    chkf(I, I);
    pulse(bus_reset_ack);
    chkf(P | I, 8'h00);
    wr(8'h26, 8'h00);
    pulse(dev_addr_written);
    chkf(T, T);
    rd(8'h26);
    chk(rd_q, 8'h00);
    rd(8'h10);
    chk(rd_q, 8'h00);
    pulse(usb_bus_reset);
    wr(8'hFF, 8'h09);
    chkf(H | C, H);
    cyc(10);
    chkf(H | C, H);
    pulse(gpio_irq_wake);
    chkf(C, C);
    cyc(4);
    chkf(H, H);
    wait_for(H, 8'h00);
    chkf(R | D | I | P, D | P);
    cyc(8);
    chkf(D | I, I);
    pulse(bus_reset_ack);
    rd(8'hFF);
    chk(rd_q, 8'h01);
    wr(8'hFF, 8'h09);
    pulse(usb_activity);
    chkf(C, C);
    wait_for(H, 8'h00);
    chkf(D, D);
    repeat (4) begin
      cyc(20);
      wr(8'h26, 8'h5A);
    end
    chkf(B, 8'h00);
    wait_for(B, B);
    chkf(B, B);
    cyc(2);
    chkf(T | P | H, H);
    wait_for(H | R, R);
    chkf(B | T, 8'h00);
    rd(8'hFF);
    chk(rd_q, 8'h41);
    wr(8'hFF, 8'h01);
    rd(8'hFF);
    chk(rd_q, 8'h01);
    nrst = 1'b0;
    cyc(2);
    chkf(H | B | T | P, H | B);
    nrst = 1'b1;
    cyc(15);
    chkf(H, H);
    rd(8'hFF);
    chk(rd_q, 8'h11);
    wait_for(H | R, R);
    chkf(H | R, R);
    end_of_test();
  end
endmodule
`default_nettype wire
